/* File: fuch_pkg.sv */
package fuch_pkg;

    // ****************************************
    // reply status characters
    // ****************************************
    localparam logic [7:0] ST_OK      = 8'h41;
    localparam logic [7:0] ST_LEN_ERR = 8'h43;
    localparam logic [7:0] ST_SEQ_ERR = 8'h53;
    localparam logic [7:0] ST_OVERRUN = 8'h4f;
    localparam logic [7:0] ST_INVALID = 8'h49;
    localparam logic [7:0] ST_FAILED  = 8'h46;

    // ****************************************
    // command characters
    // ****************************************
    localparam logic [7:0] CMD_ECHO    = 8'h58;
    localparam logic [7:0] CMD_SELECT  = 8'h57;
    localparam logic [7:0] CMD_RESTART = 8'h51;
    localparam logic [7:0] CMD_BLOCK   = 8'h44;

    // ****************************************
    // echo and block reply layout
    // ****************************************
    localparam logic [7:0]  CH_MODE    = 8'h4c;
    localparam logic [7:0]  CH_DOT     = 8'h2e;
    localparam logic [7:0]  CH_SLASH   = 8'h2f;
    localparam logic [7:0]  CH_ZERO    = 8'h30;
    localparam logic [15:0] PORT_FIELD = 16'hffff;
    localparam logic [5:0]  ECHO_LEN   = 6'h20;
    localparam logic [5:0]  ECHO_SL1   = 6'h18;
    localparam logic [5:0]  ECHO_PORT  = 6'h19;
    localparam logic [5:0]  ECHO_SL2   = 6'h1e;
    localparam logic [5:0]  BLOCK_RLEN = 6'h03;

    // ****************************************
    // upload block layout
    // ****************************************
    localparam int          BLOCK_BYTES   = 128;
    localparam logic [8:0]  BLOCK_CMD_CNT = 9'h083;
    localparam logic [8:0]  BLOCK_DATA0   = 9'h003;
    localparam logic [15:0] SIZE_BLOCK    = 16'h0001;
    localparam int          SIZE_SHIFT    = 7;

    typedef enum logic [2:0] {
        FUCH_RX,
        FUCH_EXEC,
        FUCH_FLASH,
        FUCH_FWAIT,
        FUCH_TX
    } fuch_state_t;

    typedef enum logic [1:0] {
        FUCH_R_SHORT,
        FUCH_R_ECHO,
        FUCH_R_BLOCK
    } fuch_reply_t;

endpackage

/* File: fuch_dec3.sv */
`timescale 1ns/1ns
`default_nettype none

// one octet as three ascii decimal digits
module fuch_dec3 (
    // value
    input  wire logic [7:0]  val,
    // text, hundreds digit in the top byte
    output logic      [23:0] text
);
    import fuch_pkg::*;

    always_comb
    begin
        text[23:16] = CH_ZERO + val / 8'd100;
        text[15:8]  = CH_ZERO + (val / 8'd10) % 8'd10;
        text[7:0]   = CH_ZERO + val % 8'd10;
    end

endmodule

`default_nettype wire

/* File: fuch_cmd_handler.sv */
// Function
// R1: discovery reply carries own MAC address
// R2: port field in discovery always 65535
// R3: discovery mode indicator always L
// R4: broadcast takes only discovery and select
// R5: pre-selected unit processes other broadcasts
// R6: select with other MAC clears selection
// R7: select without MAC clears selection
// R8: unicast commands ignore selection state
// R9: only matching unit replies OK to select
// R10: reset leaves the unit unselected
// R11: restart clears counter, replies OK
// R12: block body: index high first, 128 data
// R13: every block reply carries next index
// R14: OK for programmed or older block
// R15: length error unless body is 130 bytes
// R16: order error when index above expected
// R17: overrun at or past size over 128
// R18: content check only on blocks 0, 1
// R19: write failure when programming fails
// R20: host sends consecutive blocks from 0
// R21: host should restart before first block
// R22: host selects before restart or upload
// R23: discovery text: A, MAC, /port/, indicator
// R24: ignored broadcasts get no reply
`timescale 1ns/1ns
`default_nettype none

module fuch_cmd_handler #(
    parameter int         SIZE_OFS  = 4,
    parameter logic [7:0] BLK0_SIG  = 8'h00
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // unit identity
    input  wire logic [47:0] mac_addr,
    // command datagram bytes
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    input  wire logic        rx_bcast,
    output logic             rx_ready,
    // reply datagram bytes
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             tx_last,
    input  wire logic        tx_ready,
    // flash programming
    output logic             fl_valid,
    output logic [7:0]       fl_data,
    output logic             fl_last,
    output logic [15:0]      fl_index,
    input  wire logic        fl_ready,
    input  wire logic        fl_done,
    input  wire logic        fl_ok,
    // status
    output logic             selected
);
    import fuch_pkg::*;

    initial
    begin
        if (SIZE_OFS < 0 || SIZE_OFS + 3 >= BLOCK_BYTES)
            $error("SIZE_OFS outside the block");
    end

    localparam logic [39:0] PORT_TEXT = {
        CH_ZERO + 8'(PORT_FIELD / 16'd10000 % 16'd10),
        CH_ZERO + 8'(PORT_FIELD / 16'd1000 % 16'd10),
        CH_ZERO + 8'(PORT_FIELD / 16'd100 % 16'd10),
        CH_ZERO + 8'(PORT_FIELD / 16'd10 % 16'd10),
        CH_ZERO + 8'(PORT_FIELD % 16'd10)};

    // ****************************************
    // state
    // ****************************************
    fuch_state_t st_q, st_d;
    fuch_reply_t rk_q, rk_d;
    logic [7:0]  cmd_q, cmd_d;
    logic        bc_q, bc_d;
    logic [8:0]  cnt_q, cnt_d;
    logic [15:0] idx_q, idx_d;
    logic [15:0] exp_q, exp_d;
    logic [15:0] lim_q, lim_d;
    logic        limv_q, limv_d;
    logic [15:0] plim_q, plim_d;
    logic        sel_q, sel_d;
    logic [47:0] wmac_q, wmac_d;
    logic [2:0]  oix_q, oix_d;
    logic [11:0] num_q, num_d;
    logic [1:0]  ndig_q, ndig_d;
    logic        wbad_q, wbad_d;
    logic [5:0]  tptr_q, tptr_d;
    logic [5:0]  rlen_q, rlen_d;
    logic [6:0]  fptr_q, fptr_d;
    logic        rx_ready_q, rx_ready_d;
    logic        tx_valid_q, tx_valid_d;
    logic [7:0]  tx_data_q, tx_data_d;
    logic        tx_last_q, tx_last_d;
    logic        fl_valid_q, fl_valid_d;
    logic [7:0]  fl_data_q, fl_data_d;
    logic        fl_last_q, fl_last_d;

    // block data held until every check has passed, so rejected data never reaches flash
    logic [7:0]  blk_mem [BLOCK_BYTES];
    logic        mem_we;
    logic [6:0]  mem_wa;

    // ****************************************
    // mac text
    // ****************************************
    logic [23:0] mac_txt [6];

    for (genvar g = 0; g < 6; g++)
    begin : g_mac
        fuch_dec3 u_dec (
            .val  (mac_addr[47 - 8 * g -: 8]),
            .text (mac_txt[g])
        );
    end

    // ****************************************
    // decode helpers
    // ****************************************
    logic        rx_take;
    logic        in_exec;
    logic        allowed;
    logic        w_match;
    logic [31:0] fsize;
    logic        c_ok;
    logic [8:0]  p;
    logic [7:0]  dig;
    logic [5:0]  nptr;
    logic [5:0]  rel;
    logic [7:0]  nbyte;

    always_comb
    begin
        rx_take = rx_valid && rx_ready_q;
        in_exec = st_q == FUCH_EXEC;
        allowed = !bc_q || sel_q || cmd_q == CMD_ECHO || cmd_q == CMD_SELECT; // R4 R5 R8
        w_match = !wbad_q && ndig_q != 2'd0 && oix_q == 3'd5 && num_q <= 12'd255
                  && {wmac_q[47:8], num_q[7:0]} == mac_addr;
        fsize = {blk_mem[SIZE_OFS], blk_mem[SIZE_OFS + 1],
                 blk_mem[SIZE_OFS + 2], blk_mem[SIZE_OFS + 3]};
        // block 1 size must be a whole, nonzero number of blocks with a 16-bit count
        if (idx_q == 16'h0000)
            c_ok = blk_mem[0] == BLK0_SIG; // R18
        else if (idx_q == SIZE_BLOCK)
            c_ok = fsize != 32'h0 && fsize[6:0] == 7'h0 && fsize[31:23] == 9'h0; // R18
        else
            c_ok = 1'b1;
        p    = cnt_q;
        dig  = rx_data - CH_ZERO;
        nptr = tptr_q + 6'd1;
        rel  = nptr - 6'd1;
        nbyte = ST_OK;
        if (rk_q == FUCH_R_BLOCK)
            nbyte = (nptr == 6'd1) ? exp_q[15:8] : exp_q[7:0]; // R13
        else if (nptr <= 6'd23)
            nbyte = (rel[1:0] == 2'd3) ? CH_DOT
                    : mac_txt[rel[4:2]][23 - 8 * rel[1:0] -: 8]; // R1 R23
        else if (nptr == ECHO_SL1 || nptr == ECHO_SL2)
            nbyte = CH_SLASH; // R23
        else if (nptr < ECHO_SL2)
            nbyte = PORT_TEXT[39 - 8 * (nptr - ECHO_PORT) -: 8]; // R2
        else
            nbyte = CH_MODE; // R3
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_d = st_q;
        rk_d = rk_q;
        cmd_d = cmd_q;
        bc_d = bc_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        exp_d = exp_q;
        lim_d = lim_q;
        limv_d = limv_q;
        plim_d = plim_q;
        sel_d = sel_q;
        wmac_d = wmac_q;
        oix_d = oix_q;
        num_d = num_q;
        ndig_d = ndig_q;
        wbad_d = wbad_q;
        tptr_d = tptr_q;
        rlen_d = rlen_q;
        fptr_d = fptr_q;
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        tx_last_d = tx_last_q;
        fl_valid_d = fl_valid_q;
        fl_data_d = fl_data_q;
        fl_last_d = fl_last_q;
        mem_we = 1'b0;
        mem_wa = 7'h0;
        unique case (st_q)
            FUCH_RX:
            begin
                if (rx_take)
                begin
                    if (rx_first)
                    begin
                        cmd_d = rx_data;
                        bc_d = rx_bcast;
                        cnt_d = 9'h001;
                        oix_d = 3'd0;
                        num_d = 12'h0;
                        ndig_d = 2'd0;
                        wbad_d = 1'b0;
                    end
                    else
                    begin
                        cnt_d = (cnt_q == 9'h1ff) ? cnt_q : cnt_q + 9'h001;
                        if (cmd_q == CMD_BLOCK)
                        begin
                            if (p == 9'h001)
                                idx_d[15:8] = rx_data; // R12
                            else if (p == 9'h002)
                                idx_d[7:0] = rx_data; // R12
                            else if (p < BLOCK_CMD_CNT)
                            begin
                                mem_we = 1'b1;
                                mem_wa = 7'(p - BLOCK_DATA0);
                            end
                        end
                        else if (cmd_q == CMD_SELECT)
                        begin
                            if (dig <= 8'd9)
                            begin
                                num_d = num_q * 12'd10 + {4'h0, dig};
                                wbad_d = wbad_q || ndig_q == 2'd3 || num_q > 12'd255;
                                ndig_d = (ndig_q == 2'd3) ? ndig_q : ndig_q + 2'd1;
                            end
                            else if (rx_data == CH_DOT && ndig_q != 2'd0 && oix_q != 3'd5
                                     && num_q <= 12'd255)
                            begin
                                wmac_d[8 * (5 - oix_q) +: 8] = num_q[7:0];
                                oix_d = oix_q + 3'd1;
                                num_d = 12'h0;
                                ndig_d = 2'd0;
                            end
                            else
                                wbad_d = 1'b1;
                        end
                    end
                    if (rx_last)
                        st_d = FUCH_EXEC;
                end
            end
            FUCH_EXEC:
            begin
                st_d = FUCH_RX;
                tx_data_d = ST_OK;
                rk_d = FUCH_R_SHORT;
                rlen_d = 6'd1;
                tptr_d = 6'd0;
                if (!allowed)
                    st_d = FUCH_RX; // R24
                else if (cmd_q == CMD_ECHO)
                begin
                    st_d = FUCH_TX; // R1
                    rk_d = FUCH_R_ECHO;
                    rlen_d = ECHO_LEN;
                end
                else if (cmd_q == CMD_SELECT)
                begin
                    sel_d = cnt_q != 9'h001 && w_match; // R6 R7
                    if (sel_d)
                        st_d = FUCH_TX; // R9
                end
                else if (cmd_q == CMD_RESTART)
                begin
                    exp_d = 16'h0000; // R11
                    limv_d = 1'b0;
                    st_d = FUCH_TX;
                end
                else if (cmd_q == CMD_BLOCK)
                begin
                    st_d = FUCH_TX;
                    rk_d = FUCH_R_BLOCK;
                    rlen_d = BLOCK_RLEN;
                    plim_d = fsize[SIZE_SHIFT +: 16];
                    if (cnt_q != BLOCK_CMD_CNT)
                        tx_data_d = ST_LEN_ERR; // R15
                    else if (idx_q > exp_q)
                        tx_data_d = ST_SEQ_ERR; // R16
                    else if (limv_q && idx_q >= lim_q)
                        tx_data_d = ST_OVERRUN; // R17
                    else if (idx_q < exp_q)
                        tx_data_d = ST_OK; // R14
                    else if (!c_ok)
                        tx_data_d = ST_INVALID; // R18
                    else
                    begin
                        st_d = FUCH_FLASH;
                        fl_valid_d = 1'b1;
                        fl_data_d = blk_mem[0];
                        fl_last_d = 1'b0;
                        fptr_d = 7'h0;
                    end
                end
                tx_valid_d = st_d == FUCH_TX;
                tx_last_d = rlen_d == 6'd1;
            end
            FUCH_FLASH:
            begin
                if (fl_valid_q && fl_ready)
                begin
                    if (fl_last_q)
                    begin
                        fl_valid_d = 1'b0;
                        fl_last_d = 1'b0;
                        st_d = FUCH_FWAIT;
                    end
                    else
                    begin
                        fptr_d = fptr_q + 7'h1;
                        fl_data_d = blk_mem[fptr_d];
                        fl_last_d = fptr_d == 7'h7f;
                    end
                end
            end
            FUCH_FWAIT:
            begin
                if (fl_done)
                begin
                    // the index only advances once flash has confirmed the block
                    tx_data_d = fl_ok ? ST_OK : ST_FAILED; // R14 R19
                    if (fl_ok)
                    begin
                        exp_d = exp_q + 16'h0001; // R13
                        if (idx_q == SIZE_BLOCK)
                        begin
                            lim_d = plim_q; // R17
                            limv_d = 1'b1;
                        end
                    end
                    tx_valid_d = 1'b1;
                    tx_last_d = 1'b0;
                    st_d = FUCH_TX;
                end
            end
            FUCH_TX:
            begin
                if (tx_valid_q && tx_ready)
                begin
                    if (tx_last_q)
                    begin
                        tx_valid_d = 1'b0;
                        tx_last_d = 1'b0;
                        st_d = FUCH_RX;
                    end
                    else
                    begin
                        tptr_d = nptr;
                        tx_data_d = nbyte;
                        tx_last_d = nptr == rlen_q - 6'd1;
                    end
                end
            end
        endcase
        rx_ready_d = st_d == FUCH_RX;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (mem_we)
            blk_mem[mem_wa] <= rx_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= FUCH_RX;
            rk_q <= FUCH_R_SHORT;
            cmd_q <= 8'h00;
            bc_q <= 1'b0;
            cnt_q <= 9'h000;
            idx_q <= 16'h0000;
            exp_q <= 16'h0000;
            lim_q <= 16'h0000;
            limv_q <= 1'b0;
            plim_q <= 16'h0000;
            sel_q <= 1'b0; // R10
            wmac_q <= 48'h0;
            oix_q <= 3'd0;
            num_q <= 12'h0;
            ndig_q <= 2'd0;
            wbad_q <= 1'b0;
            tptr_q <= 6'd0;
            rlen_q <= 6'd1;
            fptr_q <= 7'h0;
            rx_ready_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            tx_last_q <= 1'b0;
            fl_valid_q <= 1'b0;
            fl_data_q <= 8'h00;
            fl_last_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            rk_q <= rk_d;
            cmd_q <= cmd_d;
            bc_q <= bc_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            exp_q <= exp_d;
            lim_q <= lim_d;
            limv_q <= limv_d;
            plim_q <= plim_d;
            sel_q <= sel_d;
            wmac_q <= wmac_d;
            oix_q <= oix_d;
            num_q <= num_d;
            ndig_q <= ndig_d;
            wbad_q <= wbad_d;
            tptr_q <= tptr_d;
            rlen_q <= rlen_d;
            fptr_q <= fptr_d;
            rx_ready_q <= rx_ready_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            tx_last_q <= tx_last_d;
            fl_valid_q <= fl_valid_d;
            fl_data_q <= fl_data_d;
            fl_last_q <= fl_last_d;
        end
    end

    always_comb
    begin
        rx_ready = rx_ready_q;
        tx_valid = tx_valid_q;
        tx_data  = tx_data_q;
        tx_last  = tx_last_q;
        fl_valid = fl_valid_q;
        fl_data  = fl_data_q;
        fl_last  = fl_last_q;
        fl_index = idx_q;
        selected = sel_q;
    end

    // ****************************************
    // checks
    // ****************************************
    a_reset_unselected: assert property (@(posedge clk) $past(rst) |-> !sel_q) // R10
        else $error("unit selected right after reset");
    a_bcast_drop: assert property (@(posedge clk) disable iff (rst) // R24
        in_exec && bc_q && !sel_q && cmd_q != CMD_ECHO && cmd_q != CMD_SELECT
        |=> !tx_valid_q && st_q == FUCH_RX)
        else $error("unselected broadcast command produced activity");
    a_echo_indicator: assert property (@(posedge clk) disable iff (rst) // R3
        tx_valid_q && tx_last_q && rk_q == FUCH_R_ECHO |-> tx_data_q == CH_MODE)
        else $error("echo reply does not end in mode indicator");
    a_echo_port: assert property (@(posedge clk) disable iff (rst) // R2
        tx_valid_q && rk_q == FUCH_R_ECHO && tptr_q == ECHO_PORT
        |-> tx_data_q == PORT_TEXT[39:32])
        else $error("echo port field wrong");
    a_restart_ok: assert property (@(posedge clk) disable iff (rst) // R11
        in_exec && allowed && cmd_q == CMD_RESTART
        |=> exp_q == 16'h0000 && tx_valid_q && tx_last_q && tx_data_q == ST_OK)
        else $error("restart did not clear counter or answer OK");
    a_len_error: assert property (@(posedge clk) disable iff (rst) // R15
        in_exec && allowed && cmd_q == CMD_BLOCK && cnt_q != BLOCK_CMD_CNT
        |=> tx_data_q == ST_LEN_ERR ##0 $stable(exp_q))
        else $error("bad block length not reported");
    a_seq_error: assert property (@(posedge clk) disable iff (rst) // R16
        in_exec && allowed && cmd_q == CMD_BLOCK && cnt_q == BLOCK_CMD_CNT && idx_q > exp_q
        |=> tx_data_q == ST_SEQ_ERR)
        else $error("block ahead of expected not reported");
    a_fail_hold: assert property (@(posedge clk) disable iff (rst) // R13 R19
        st_q == FUCH_FWAIT && fl_done && !fl_ok
        |=> tx_data_q == ST_FAILED && exp_q == $past(exp_q))
        else $error("failed block changed index or status");
    a_sel_clear: assert property (@(posedge clk) disable iff (rst) // R6 R7 R9
        in_exec && allowed && cmd_q == CMD_SELECT && (cnt_q == 9'h001 || !w_match)
        |=> !sel_q && !tx_valid_q)
        else $error("select without own address kept selection or replied");

endmodule

`default_nettype wire

/* File: fuch_host.sv */
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// remote host: command sender, reply sink
// ****************************************
module fuch_host (
    // clock
    input  wire logic       clk,
    // command datagram bytes
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_first,
    output logic            rx_last,
    output logic            rx_bcast,
    input  wire logic       rx_ready,
    // reply datagram bytes
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    output logic            tx_ready
);
    logic [7:0] rq[$];
    logic       last_seen;

    initial
    begin
        {rx_valid, rx_first, rx_last, rx_bcast, tx_ready, last_seen} = '0;
        rx_data = 8'h00;
    end

    // slow sink, takes a reply byte only every second cycle
    always @(posedge clk)
    begin
        tx_ready <= ~tx_ready;
        if (tx_valid && tx_ready)
        begin
            rq.push_back(tx_data);
            last_seen <= tx_last;
        end
    end

    // whole datagram; each byte held until the edge that takes it
    task automatic send(input logic [7:0] b[$], input logic bc);
        @(posedge clk);
        for (int i = 0; i < b.size(); i++)
        begin
            rx_valid <= 1'b1;
            rx_data  <= b[i];
            rx_first <= (i == 0);
            rx_last  <= (i == b.size() - 1);
            rx_bcast <= bc;
            do @(negedge clk); while (rx_ready !== 1'b1);
            @(posedge clk);
        end
        // released lane shows junk
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
        rx_bcast <= ~bc;
    endtask
endmodule

`default_nettype wire

/* File: fuch_cmd_handler_bench.sv */
`timescale 1ns/1ns
`default_nettype none

module fuch_cmd_handler_bench import fuch_pkg::*;;
    typedef logic [7:0] fuch_bq_t[$];
    typedef struct {
        logic [7:0] c; logic b; logic [15:0] i; logic [7:0] l; logic [1:0] m;
        logic [5:0] n; logic [7:0] s; logic [15:0] x; logic e; logic f;
    } fuch_row_t;

    localparam logic [47:0] UNIT_MAC = 48'h0a_b1_2c_ff_00_07;
    logic        clk, rst, rx_valid, rx_first, rx_last, rx_bcast, rx_ready;
    logic [7:0]  rx_data, tx_data, fl_data;
    logic        tx_valid, tx_last, tx_ready, fl_valid, fl_last, fl_ready;
    logic        fl_done, fl_ok, fok, selected;
    logic [15:0] fl_index;
    int          nfl, fwait, cyc, failures, n_tests;
    fuch_bq_t    ex;

    // ****************************************
    // ordinary cases: command, broadcast, index or mac choice, body length,
    // data mode, reply length, status, next index, selected, programmed
    // ****************************************
    fuch_row_t rows[18] = '{
        '{CMD_RESTART, 0, 0, 0, 0, 1, ST_OK, 0, 0, 0},
        '{CMD_BLOCK, 0, 0, 130, 0, 3, ST_OK, 1, 0, 1},
        '{CMD_BLOCK, 0, 2, 130, 0, 3, ST_SEQ_ERR, 1, 0, 0},
        '{CMD_BLOCK, 0, 1, 130, 0, 3, ST_OK, 2, 0, 1},
        '{CMD_BLOCK, 0, 0, 130, 0, 3, ST_OK, 2, 0, 0},
        '{CMD_BLOCK, 0, 2, 130, 0, 3, ST_OVERRUN, 2, 0, 0},
        '{CMD_BLOCK, 0, 2, 129, 0, 3, ST_LEN_ERR, 2, 0, 0},
        '{CMD_RESTART, 0, 0, 0, 0, 1, ST_OK, 0, 0, 0},
        '{CMD_BLOCK, 0, 0, 130, 1, 3, ST_INVALID, 0, 0, 0},
        '{CMD_BLOCK, 0, 0, 130, 2, 3, ST_FAILED, 0, 0, 1},
        '{CMD_RESTART, 1, 0, 0, 0, 0, 0, 0, 0, 0},
        '{CMD_ECHO, 1, 0, 0, 0, 32, ST_OK, 0, 0, 0},
        '{CMD_SELECT, 1, 0, 0, 0, 1, ST_OK, 0, 1, 0},
        '{CMD_RESTART, 1, 0, 0, 0, 1, ST_OK, 0, 1, 0},
        '{CMD_SELECT, 1, 2, 0, 0, 0, 0, 0, 0, 0},
        '{CMD_SELECT, 1, 0, 0, 0, 1, ST_OK, 0, 1, 0},
        '{CMD_SELECT, 1, 1, 0, 0, 0, 0, 0, 0, 0},
        '{CMD_SELECT, 1, 0, 0, 0, 1, ST_OK, 0, 1, 0}};

    fuch_cmd_handler u_dut (.clk(clk), .rst(rst), .mac_addr(UNIT_MAC), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last), .rx_bcast(rx_bcast),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .fl_valid(fl_valid), .fl_data(fl_data), .fl_last(fl_last),
        .fl_index(fl_index), .fl_ready(fl_ready), .fl_done(fl_done), .fl_ok(fl_ok),
        .selected(selected));
    fuch_host u_host (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_first(rx_first), .rx_last(rx_last), .rx_bcast(rx_bcast), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // flash stalls alternate cycles, done 3 after last byte; nfl sums data, fl_last
    always @(posedge clk)
    begin
        fl_ready <= ~fl_ready;
        fl_done <= 1'b0;
        cyc <= cyc + 1;
        if (fl_valid && fl_ready)
            nfl <= nfl + 1 + (fl_data << 8) + (fl_last << 16);
        if (fl_valid && fl_ready && fl_last)
            fwait <= 3;
        else if (fwait != 0)
            fwait <= fwait - 1;
        if (fwait == 1)
        begin
            fl_done <= 1'b1;
            fl_ok <= fok;
        end
        if (cyc == 20000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic fuch_bq_t mac_text(input logic [47:0] m);
        fuch_bq_t t;
        for (int o = 5; o >= 0; o--)
        begin
            if (o < 5)
                t.push_back(CH_DOT);
            for (int d = 100; d > 0; d /= 10)
                t.push_back(CH_ZERO + 8'((m[o*8 +: 8] / d) % 10));
        end
        return t;
    endfunction

    task automatic run(input fuch_row_t r);
        fuch_bq_t q;
        int       w;
        int       f0;
        q = {r.c};
        f0 = nfl;
        fok = (r.m != 2'd2);
        if (r.c == CMD_SELECT && r.i != 16'd2)
            q = {q, mac_text(UNIT_MAC ^ 48'(r.i))};
        if (r.c == CMD_BLOCK)
            q = {q, r.i[15:8], r.i[7:0]};
        // size 256 sits big-endian at data bytes 4..7, signature byte first
        for (int k = 2; k < r.l; k++)
            q.push_back(k == 2 ? (r.m == 2'd1 ? 8'h55 : 8'h00) : (k == 8 ? 8'h01 : 8'h00));
        u_host.rq.delete();
        u_host.last_seen = 1'b0;
        u_host.send(q, r.b);
        w = 0;
        repeat (3) @(negedge clk);
        while (!(rx_ready === 1'b1 && u_host.rq.size() >= r.n) && w < 2000)
        begin
            @(negedge clk);
            w++;
        end
        repeat (4) @(negedge clk);
        check("reply length", u_host.rq.size(), r.n);
        if (r.n != 0)
            check("status", u_host.rq[0], r.s);
        if (r.n != 0)
            check("last flag", u_host.last_seen, 1'b1);
        if (r.n == 3)
            check("block index", {fl_index, u_host.rq[1], u_host.rq[2]}, {r.i, r.x});
        if (r.n == 32)
            foreach (ex[k]) check("echo byte", u_host.rq[k], ex[k]);
        check("selected", selected, r.e);
        check("flash bytes", nfl - f0, r.f ? 32'h10180 : 0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // main sequence, then reset after a selection
    // ****************************************
    initial
    begin
        {rst, fl_ready, fl_done, fl_ok, fok} = 5'b10000;
        {nfl, fwait, cyc, failures, n_tests} = '0;
        ex = {ST_OK, mac_text(UNIT_MAC), CH_SLASH};
        for (int d = 10000; d > 0; d /= 10)
            ex.push_back(CH_ZERO + 8'((PORT_FIELD / d) % 10));
        ex = {ex, CH_SLASH, CH_MODE};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        check("rx_ready", rx_ready, 1'b1);
        check("selected", selected, 1'b0);
        foreach (rows[r]) run(rows[r]);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("selected", selected, 1'b0);
        test_done();
    end
endmodule

`default_nettype wire
